// >>> logic/spd_pkg.sv
// shared constants, types and helpers of the phase delay block
package spd_pkg;

  // ==========================================================
  // register port and index space
  localparam logic       PORT_INDEX    = 1'b0;
  localparam logic       PORT_DATA     = 1'b1;
  localparam logic [7:0] IDX_SYNC_CTRL = 8'h00;
  localparam logic [7:0] IDX_CLK_DIV   = 8'h03;
  localparam logic [7:0] IDX_PHASE_SEL = 8'h04;
  localparam logic [7:0] IDX_RES_SEL   = 8'h05;
  localparam logic [7:0] IDX_SOFT_RST  = 8'h08;
  localparam logic [7:0] IDX_LOW_LAST  = 8'h08;
  localparam logic [7:0] IDX_HIGH_FRST = 8'h10;
  localparam logic [7:0] IDX_STATUS    = 8'h11;
  localparam logic [7:0] IDX_HIGH_LAST = 8'h12;

  // ==========================================================
  // field positions and codes
  localparam int         SYNC_EDGE_BIT = 2;
  localparam int         OFFSET_EN_BIT = 6;
  localparam logic [3:0] SOFT_RST_CODE = 4'ha;
  localparam logic [1:0] RES_16        = 2'b00;
  localparam logic [1:0] RES_32        = 2'b01;
  localparam logic [1:0] RES_RSV       = 2'b10;
  localparam logic [1:0] RES_64        = 2'b11;

  // ==========================================================
  // reset values and timing
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [7:0] CLK_DIV_RST   = 8'h03;
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         MARKER_NS     = 200;
  localparam int         MARKER_CYC    = (MARKER_NS / CLK_PERIOD_NS < 1)
                                         ? 1 : MARKER_NS / CLK_PERIOD_NS;
  localparam int         DLY_W         = 15;

  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_MARK} spd_phase_t;

  // ==========================================================
  // element count helpers
  function automatic logic [2:0] elem_shift(input logic [1:0] res);
    unique case (res)
      RES_32:  elem_shift = 3'd5;
      RES_64:  elem_shift = 3'd6;
      default: elem_shift = 3'd4;
    endcase
  endfunction : elem_shift

  function automatic logic [5:0] elem_max(input logic [1:0] res);
    unique case (res)
      RES_32:  elem_max = 6'h1f;
      RES_64:  elem_max = 6'h3f;
      default: elem_max = 6'h0f;
    endcase
  endfunction : elem_max

endpackage : spd_pkg

// >>> logic/spd_link_if.sv
// signals between the core and its edge and delay helpers
`timescale 1ns/1ns
interface spd_link_if;
  logic                     sync_edge;
  logic [7:0]               period;
  logic [5:0]               count;
  logic [1:0]               res;
  logic [spd_pkg::DLY_W-1:0] delay;

  modport edge_src (output sync_edge);
  modport calc     (input period, count, res, output delay);
  modport core     (input sync_edge, delay, output period, count, res);
endinterface : spd_link_if

// >>> logic/spd_sync_edge.sv
// selected edge detector on the line sync input
`timescale 1ns/1ns
module spd_sync_edge (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // line side
  input  wire logic line_sync,
  input  wire logic edge_fall,
  // to the core
  spd_link_if.edge_src lk
);

  typedef struct packed {
    logic prev;
    logic pulse;
  } spd_edge_state_t;

  spd_edge_state_t s;
  spd_edge_state_t next_s;

  // ==========================================================
  // edge pick: rising when clear, falling when set
  always_comb begin
    next_s       = s;
    next_s.prev  = line_sync;
    next_s.pulse = edge_fall ? (s.prev && !line_sync)
                             : (!s.prev && line_sync);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lk.sync_edge = s.pulse;

  edge_sel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s.pulse |-> $past(line_sync) == !$past(edge_fall)
      && $past(line_sync, 2) == $past(edge_fall))
    else $error("sync edge pulse on the wrong edge");

endmodule : spd_sync_edge

// >>> logic/spd_delay_calc.sv
// phase delay in clock cycles from period, element count and resolution
`timescale 1ns/1ns
module spd_delay_calc (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // settings in, delay out
  spd_link_if.calc lk
);

  typedef struct packed {
    logic [spd_pkg::DLY_W-1:0] delay;
  } spd_calc_state_t;

  spd_calc_state_t s;
  spd_calc_state_t next_s;

  // ==========================================================
  // period times count over total; count beyond the range is masked
  always_comb begin
    logic [spd_pkg::DLY_W-1:0] prod;
    prod = spd_pkg::DLY_W'({1'b0, lk.period} + 9'h001)
         * spd_pkg::DLY_W'(lk.count & spd_pkg::elem_max(lk.res));
    next_s       = s;
    next_s.delay = prod >> spd_pkg::elem_shift(lk.res);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lk.delay = s.delay;

  delay_calc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    lk.res == spd_pkg::RES_64 |=> lk.delay ==
      ($past(lk.period) + 15'h0001) * $past(lk.count) / 64)
    else $error("phase delay not period times count over 64");

  res16_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    lk.res == spd_pkg::RES_16 |=> lk.delay ==
      ($past(lk.period) + 15'h0001) * $past(lk.count[3:0]) / 16)
    else $error("sixteen element setting misdecoded");

endmodule : spd_delay_calc

// >>> logic/spd_top.sv
// phase delay core: register port, marker, lock and half-rate clock
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
// Notes on behaviour
// - each data byte written or read moves the low index nibble up by one.
// - the high index nibble never takes a carry and changes only by address.
// - phase delay is output period times selected count over total count.
// - resolution 00 gives 16, 01 gives 32, 11 gives 64 elements; 10 unused.
// - the working resolution loads only when hex A hits index 8 low nibble.
// - control bit 2 of index 0 picks the rising or falling sync edge.
// - marker pulses once per line sync period; lock output follows line sync a cycle late.
// - the half-rate clock always has one fixed phase at the marker's fall.
// - the negative half-rate output is always the positive one inverted.
module spd_top (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic       reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // line side
  input  wire logic       line_sync,
  output logic            phase_marker_out,
  output logic            lock_ref_out,
  output logic            clk_half_p,
  output logic            clk_half_n
);

  typedef struct packed {
    logic [31:0][7:0]          regs;
    logic [7:0]                idx;
    logic [7:0]                rdata;
    logic [1:0]                res_work;
    logic [7:0]                div_cnt;
    logic [spd_pkg::DLY_W-1:0] dly_cnt;
    logic [3:0]                mk_cnt;
    spd_pkg::spd_phase_t       phase;
    logic                      marker;
    logic                      lock_ref;
    logic                      half_p;
    logic                      half_n;
  } spd_core_state_t;

  spd_core_state_t s;
  spd_core_state_t next_s;
  spd_link_if      lk ();
  logic            offset_en;

  // ==========================================================
  // index helpers
  function automatic logic [7:0] next_index(input logic [7:0] idx);
    next_index = {idx[7:4], idx[3:0] + 4'h1};
  endfunction : next_index

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx <= spd_pkg::IDX_LOW_LAST)
          || (idx >= spd_pkg::IDX_HIGH_FRST
              && idx <= spd_pkg::IDX_HIGH_LAST);
  endfunction : mapped

  // ==========================================================
  // helpers
  spd_sync_edge u_edge (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .line_sync (line_sync),
    .edge_fall (s.regs[spd_pkg::IDX_SYNC_CTRL[4:0]][spd_pkg::SYNC_EDGE_BIT]),
    .lk        (lk.edge_src)
  );

  spd_delay_calc u_calc (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .lk      (lk.calc)
  );

  // settings that steer the delay path
  assign lk.period = s.regs[spd_pkg::IDX_CLK_DIV[4:0]];
  assign lk.count  = s.regs[spd_pkg::IDX_PHASE_SEL[4:0]][5:0];
  assign lk.res    = s.res_work;
  assign offset_en = s.regs[spd_pkg::IDX_PHASE_SEL[4:0]]
                           [spd_pkg::OFFSET_EN_BIT];

  // ==========================================================
  // next state
  always_comb begin
    next_s          = s;
    next_s.rdata    = 8'h00;
    next_s.lock_ref = line_sync;

    // register port: index byte, then auto-stepping data bytes
    if (reg_wr) begin
      if (reg_addr == spd_pkg::PORT_INDEX) begin
        next_s.idx = reg_wdata;
      end else begin
        if (mapped(s.idx) && s.idx != spd_pkg::IDX_STATUS) begin
          next_s.regs[s.idx[4:0]] = reg_wdata;
        end
        // shadow copy is only taken on the soft reset code
        if (s.idx == spd_pkg::IDX_SOFT_RST
            && reg_wdata[3:0] == spd_pkg::SOFT_RST_CODE
            && s.regs[spd_pkg::IDX_RES_SEL[4:0]][1:0]
               != spd_pkg::RES_RSV) begin
          next_s.res_work = s.regs[spd_pkg::IDX_RES_SEL[4:0]][1:0];
        end
        next_s.idx = next_index(s.idx);
      end
    end else if (reg_rd) begin
      if (reg_addr == spd_pkg::PORT_INDEX) begin
        next_s.rdata = s.idx;
      end else begin
        if (s.idx == spd_pkg::IDX_STATUS) begin
          next_s.rdata = {5'h00, s.marker, s.res_work};
        end else if (mapped(s.idx)) begin
          next_s.rdata = s.regs[s.idx[4:0]];
        end
        next_s.idx = next_index(s.idx);
      end
    end

    // half-rate clock: one toggle per output clock period
    if (s.div_cnt == 8'h00) begin
      next_s.div_cnt = lk.period;
      next_s.half_p  = !s.half_p;
      next_s.half_n  = s.half_p;
    end else begin
      next_s.div_cnt = s.div_cnt - 8'h01;
    end

    // marker: delayed by the phase offset, fixed width
    unique case (s.phase)
      spd_pkg::PH_IDLE: begin
        if (lk.sync_edge) begin
          if (offset_en && lk.delay != '0) begin
            next_s.phase   = spd_pkg::PH_WAIT;
            next_s.dly_cnt = lk.delay;
          end else begin
            // offset select clear bypasses the delay chain
            next_s.phase  = spd_pkg::PH_MARK;
            next_s.marker = 1'b1;
            next_s.mk_cnt = 4'(spd_pkg::MARKER_CYC - 1);
          end
        end
      end
      spd_pkg::PH_WAIT: begin
        if (s.dly_cnt == spd_pkg::DLY_W'(1)) begin
          next_s.phase  = spd_pkg::PH_MARK;
          next_s.marker = 1'b1;
          next_s.mk_cnt = 4'(spd_pkg::MARKER_CYC - 1);
        end else begin
          next_s.dly_cnt = s.dly_cnt - spd_pkg::DLY_W'(1);
        end
      end
      spd_pkg::PH_MARK: begin
        if (s.mk_cnt == 4'h0) begin
          // realign so every line starts with the same half-rate phase
          next_s.phase   = spd_pkg::PH_IDLE;
          next_s.marker  = 1'b0;
          next_s.half_p  = 1'b0;
          next_s.half_n  = 1'b1;
          next_s.div_cnt = lk.period;
        end else begin
          next_s.mk_cnt = s.mk_cnt - 4'h1;
        end
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s                                  <= '0;
      s.regs[spd_pkg::IDX_CLK_DIV[4:0]]  <= spd_pkg::CLK_DIV_RST;
      s.res_work                         <= spd_pkg::RES_16;
      s.phase                            <= spd_pkg::PH_IDLE;
      s.half_n                           <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs, each a flop
  assign reg_rdata        = s.rdata;
  assign phase_marker_out = s.marker;
  assign lock_ref_out     = s.lock_ref;
  assign clk_half_p       = s.half_p;
  assign clk_half_n       = s.half_n;

  // ==========================================================
  // checks
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  nibble_step_a: assert property (
    (reg_wr || reg_rd) && reg_addr == spd_pkg::PORT_DATA
    |=> s.idx[3:0] == $past(s.idx[3:0]) + 4'h1)
    else $error("low index nibble did not step");

  high_hold_a: assert property (
    !(reg_wr && reg_addr == spd_pkg::PORT_INDEX)
    |=> s.idx[7:4] == $past(s.idx[7:4]))
    else $error("high index nibble moved without address");

  res_load_a: assert property (
    s.res_work != $past(s.res_work)
    |-> $past(reg_wr && reg_addr == spd_pkg::PORT_DATA
              && s.idx == spd_pkg::IDX_SOFT_RST
              && reg_wdata[3:0] == spd_pkg::SOFT_RST_CODE))
    else $error("working resolution changed without soft reset");

  res_legal_a: assert property (
    s.res_work != spd_pkg::RES_RSV)
    else $error("reserved resolution in working copy");

  bypass_mark_a: assert property (
    lk.sync_edge && s.phase == spd_pkg::PH_IDLE && !offset_en
    |=> $rose(phase_marker_out))
    else $error("bypassed marker not immediate");

  marker_width_a: assert property (
    $rose(phase_marker_out)
    |-> phase_marker_out [*5] ##1 !phase_marker_out)
    else $error("marker width wrong");

  lock_follow_a: assert property (
    1'b1 |=> lock_ref_out == $past(line_sync))
    else $error("lock output does not follow line sync");

  half_fix_a: assert property (
    $fell(phase_marker_out) |-> !clk_half_p)
    else $error("half-rate phase not fixed at marker fall");

  half_comp_a: assert property (
    clk_half_n == !clk_half_p)
    else $error("half-rate outputs not complementary");

  // ==========================================================
  // register port checks: index load, idle read data, dropped writes
  idx_load_a: assert property (
    reg_wr && reg_addr == spd_pkg::PORT_INDEX
    |=> s.idx == $past(reg_wdata))
    else $error("index byte not loaded");

  idx_read_a: assert property (
    reg_rd && reg_addr == spd_pkg::PORT_INDEX
    |=> reg_rdata == $past(s.idx))
    else $error("index read returned the wrong byte");

  // read data must not linger, or a late sample would look valid
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data stands outside its cycle");

  status_ro_a: assert property (
    reg_wr && reg_addr == spd_pkg::PORT_DATA
    && s.idx == spd_pkg::IDX_STATUS
    |=> $stable(s.regs))
    else $error("write to status index changed a register");

  unmapped_rd_a: assert property (
    reg_rd && reg_addr == spd_pkg::PORT_DATA && !mapped(s.idx)
    |=> reg_rdata == 8'h00)
    else $error("unmapped index read not zero");

  // ==========================================================
  // marker path checks: quiet while waiting, rise only from an edge
  marker_idle_a: assert property (
    s.phase == spd_pkg::PH_IDLE |-> !phase_marker_out)
    else $error("marker high while idle");

  wait_quiet_a: assert property (
    s.phase == spd_pkg::PH_WAIT |-> !phase_marker_out)
    else $error("marker high during the offset wait");

  wait_exit_a: assert property (
    s.phase == spd_pkg::PH_WAIT && s.dly_cnt == spd_pkg::DLY_W'(1)
    |=> $rose(phase_marker_out))
    else $error("marker late after the offset wait");

  mark_cause_a: assert property (
    $rose(phase_marker_out)
    |-> $past(lk.sync_edge) || $past(s.phase) == spd_pkg::PH_WAIT)
    else $error("marker rose without a sync edge");

  // half-rate clock holds between divider wraps outside the marker phase
  half_hold_a: assert property (
    s.div_cnt != 8'h00 && s.phase != spd_pkg::PH_MARK
    |=> $stable(clk_half_p))
    else $error("half-rate clock moved between wraps");

  soft_rst_c: cover property (
    reg_wr && s.idx == spd_pkg::IDX_SOFT_RST
    && reg_wdata[3:0] == spd_pkg::SOFT_RST_CODE);
  delayed_mark_c: cover property (
    s.phase == spd_pkg::PH_WAIT ##[1:300] $rose(phase_marker_out));
  nibble_wrap_c: cover property (
    reg_wr && reg_addr == spd_pkg::PORT_DATA && s.idx[3:0] == 4'hf);
  // falling edge mode seen at least once
  fall_edge_c: cover property (
    lk.sync_edge
    && s.regs[spd_pkg::IDX_SYNC_CTRL[4:0]][spd_pkg::SYNC_EDGE_BIT]);

endmodule : spd_top

// >>> verification/spd_host_model.sv
// host model driving the register port of the phase delay block
`timescale 1ns/1ns
module spd_host_model (
  // clock
  input  wire logic       ref_clk,
  // register port
  output logic            reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle port at time zero
  initial begin
    reg_addr  = 1'b0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one-cycle write; idle data inverted so stale bytes never look valid
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // one-cycle read; data stand only in the cycle after the strobe
  task automatic rd(input logic a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // every access names its index first, no reliance on stepping
  task automatic set_reg(input logic [7:0] i, input logic [7:0] d);
    wr(spd_pkg::PORT_INDEX, i);
    wr(spd_pkg::PORT_DATA, d);
  endtask : set_reg

  task automatic get_reg(input logic [7:0] i, output logic [7:0] d);
    wr(spd_pkg::PORT_INDEX, i);
    rd(spd_pkg::PORT_DATA, d);
  endtask : get_reg
endmodule : spd_host_model

// >>> verification/spd_top_tb.sv
// self-checking testbench of the phase delay block
`timescale 1ns/1ns
module spd_top_tb;
  // ==========================================================
  // signals
  logic       ref_clk;
  logic       reset_n;
  logic       line_sync;
  logic       reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       phase_marker_out;
  logic       lock_ref_out;
  logic       clk_half_p;
  logic       clk_half_n;
  int         err_count;
  int         num_checks;
  logic [7:0] v;

  spd_top spd_top_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_sync(line_sync),
    .phase_marker_out(phase_marker_out), .lock_ref_out(lock_ref_out),
    .clk_half_p(clk_half_p), .clk_half_n(clk_half_n)
  );

  spd_host_model spd_host_model_inst (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic reg_chk(input string nm, input logic [7:0] i,
                         input logic [7:0] e);
    spd_host_model_inst.get_reg(i, v);
    chk(nm, e, v);
  endtask : reg_chk

  // one sync edge: cycles to marker rise (0 = none), width, half clock
  task automatic sync_go(input logic lvl, input int exp_rise);
    int i;
    int w;
    @(posedge ref_clk);
    line_sync <= lvl;
    i = 0;
    repeat (12) begin
      @(posedge ref_clk);
      #1;
      i++;
      if (i == 1) chk("lock_ref_out", {7'h0, lvl}, {7'h0, lock_ref_out});
      if (phase_marker_out === 1'b1) break;
    end
    if (phase_marker_out !== 1'b1) i = 0;
    chk("marker delay", exp_rise[7:0], i[7:0]);
    if (i != 0) begin
      w = 0;
      while (phase_marker_out === 1'b1 && w < 10) begin
        @(posedge ref_clk);
        #1;
        w++;
      end
      chk("marker width", 8'h05, w[7:0]);
      chk("half_p at fall", 8'h00, {7'h0, clk_half_p});
    end
  endtask : sync_go

  task automatic test_done;
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // clock, complement monitor and watchdog
  always #20 ref_clk = ~ref_clk;

  // the two half-rate outputs must never agree, also during reset
  always @(negedge ref_clk) begin
    chk("clk_half_n", {7'h0, ~clk_half_p}, {7'h0, clk_half_n});
  end

  // the run needs about 330 cycles; 10000 means a hang
  initial begin
    #400000;
    err_count++;
    test_done();
  end

  // ==========================================================
  // main sequence
  initial begin
    ref_clk    = 1'b0;
    reset_n    = 1'b0;
    line_sync  = 1'b0;
    err_count  = 0;
    num_checks = 0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    reg_chk("period reset", spd_pkg::IDX_CLK_DIV, 8'h03);
    spd_host_model_inst.rd(spd_pkg::PORT_INDEX, v);
    chk("index step", 8'h04, v);
    spd_host_model_inst.set_reg(8'h0f, 8'hff);
    spd_host_model_inst.rd(spd_pkg::PORT_INDEX, v);
    chk("low wrap", 8'h00, v);
    reg_chk("unmapped", 8'h1f, 8'h00);
    spd_host_model_inst.rd(spd_pkg::PORT_INDEX, v);
    chk("no carry", 8'h10, v);
    spd_host_model_inst.set_reg(spd_pkg::IDX_STATUS, 8'hff);
    reg_chk("status ro", spd_pkg::IDX_STATUS, 8'h00);
    spd_host_model_inst.set_reg(spd_pkg::IDX_HIGH_LAST, 8'h5a);
    reg_chk("index 12", spd_pkg::IDX_HIGH_LAST, 8'h5a);
    // back-to-back data writes land in consecutive indices
    spd_host_model_inst.set_reg(spd_pkg::IDX_CLK_DIV, 8'h03);
    spd_host_model_inst.wr(spd_pkg::PORT_DATA, 8'h48);
    reg_chk("step write", spd_pkg::IDX_PHASE_SEL, 8'h48);
    // bypass first: clear the enable that the step write has set
    spd_host_model_inst.set_reg(spd_pkg::IDX_PHASE_SEL, 8'h00);
    sync_go(1'b1, 2);
    sync_go(1'b0, 0);
    spd_host_model_inst.set_reg(spd_pkg::IDX_SYNC_CTRL, 8'h04);
    sync_go(1'b1, 0);
    sync_go(1'b0, 2);
    spd_host_model_inst.set_reg(spd_pkg::IDX_SYNC_CTRL, 8'h00);
    // 16 elements, period 4, count 8: delay 2
    spd_host_model_inst.set_reg(spd_pkg::IDX_PHASE_SEL, 8'h48);
    sync_go(1'b1, 4);
    sync_go(1'b0, 0);
    // count 1f masked to 0f: delay 3
    spd_host_model_inst.set_reg(spd_pkg::IDX_PHASE_SEL, 8'h5f);
    sync_go(1'b1, 5);
    sync_go(1'b0, 0);
    // new resolution waits for the soft reset
    spd_host_model_inst.set_reg(spd_pkg::IDX_RES_SEL, 8'h03);
    spd_host_model_inst.set_reg(spd_pkg::IDX_PHASE_SEL, 8'h60);
    reg_chk("res held", spd_pkg::IDX_STATUS, 8'h00);
    sync_go(1'b1, 2);
    sync_go(1'b0, 0);
    spd_host_model_inst.set_reg(spd_pkg::IDX_SOFT_RST, 8'h0a);
    reg_chk("res loaded", spd_pkg::IDX_STATUS, 8'h03);
    sync_go(1'b1, 4);
    sync_go(1'b0, 0);
    spd_host_model_inst.set_reg(spd_pkg::IDX_RES_SEL, 8'h02);
    spd_host_model_inst.set_reg(spd_pkg::IDX_SOFT_RST, 8'h0a);
    reg_chk("res reserved", spd_pkg::IDX_STATUS, 8'h03);
    spd_host_model_inst.set_reg(spd_pkg::IDX_RES_SEL, 8'h01);
    spd_host_model_inst.set_reg(spd_pkg::IDX_SOFT_RST, 8'h0a);
    spd_host_model_inst.set_reg(spd_pkg::IDX_PHASE_SEL, 8'h50);
    reg_chk("res 32", spd_pkg::IDX_STATUS, 8'h01);
    sync_go(1'b1, 4);
    sync_go(1'b0, 0);
    // period 8, 32 elements, count 16: delay 4
    spd_host_model_inst.set_reg(spd_pkg::IDX_CLK_DIV, 8'h07);
    sync_go(1'b1, 6);
    sync_go(1'b0, 0);
    spd_host_model_inst.set_reg(spd_pkg::IDX_PHASE_SEL, 8'h10);
    sync_go(1'b1, 2);
    sync_go(1'b0, 0);
    test_done();
  end
endmodule : spd_top_tb
